// *** dv/testbench.sv ***
/*
  self-checking bench for crbu_top: steps the four phases, feeds words, flags,
  pc and register accesses, and compares with an integer model each cycle.
  assumes the design files and crbu_defs.svh are compiled before this file.
*/
`timescale 1ns/10ps
`default_nettype none
module testbench;
  localparam int PCW = 21;
  // clock and reset
  logic clock, rst;
  // core side stimulus and results
  logic [1:0] q_phase;
  logic [15:0] instr;
  logic instr_valid, flag_neg, flag_carry, flag_ovf, flag_zero;
  logic [PCW-1:0] pc_inc, pc_target;
  logic pc_load, fetch_flush, nop_cycle, branch_busy, status_we;
  // register port
  logic [3:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic reg_we, reg_re;
  // model state and counters
  int mismatches, samples_checked, en, cnt, lkind, ltaken, prev_br, i;
  logic [3:0] ops [5] = '{4'h6, 4'h3, 4'h7, 4'h5, 4'h1};
  logic [15:0] w;
  crbu_top #(.PCW(PCW), .CNTW(16)) dut (.clock(clock), .rst(rst), .q_phase(q_phase),
    .instr(instr), .instr_valid(instr_valid), .flag_neg(flag_neg), .flag_carry(flag_carry),
    .flag_ovf(flag_ovf), .flag_zero(flag_zero), .pc_inc(pc_inc), .pc_load(pc_load),
    .pc_target(pc_target), .fetch_flush(fetch_flush), .nop_cycle(nop_cycle),
    .branch_busy(branch_busy), .status_we(status_we), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata));
  // free running clock, 25 ns
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  // one comparison, counted
  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  // model decode: kind code of a word, 0 when not a branch
  function automatic int kind_of(logic [15:0] x);
    if (x[15:12] != 4'he) return 0;
    case (x[11:8])
      4'h6: return 1;
      4'h3: return 2;
      4'h7: return 3;
      4'h5: return 4;
      4'h1: return 5;
      default: return 0;
    endcase
  endfunction
  // model condition; f is {neg, carry, ovf, zero}
  function automatic int cond(int k, logic [3:0] f);
    case (k)
      1: return f[3];
      2: return !f[2];
      3: return !f[3];
      4: return !f[1];
      default: return !f[0];
    endcase
  endfunction
  // one instruction cycle, register read or write in its Q1, then the empty cycle when taken
  task automatic run_cycle(input logic [15:0] x, input logic v, input logic [3:0] f,
                           input logic [PCW-1:0] pc, input logic wr, input logic [31:0] wd);
    int k, tk, ra, j;
    logic [PCW-1:0] tgt;
    logic [31:0] er;
    k = (en != 0 && v) ? kind_of(x) : 0;
    tk = (k != 0) && (cond(k, f) != 0);
    tgt = pc + {{(PCW-9){x[7]}}, x[7:0], 1'b0};
    ra = 4 * ($urandom % 4);
    if (ra == 4 && prev_br == 0) ra = 8;
    er = (ra == 0) ? en : (ra == 4) ? {ltaken[0], lkind[2:0], 1'b0} : (ra == 8) ? cnt : 0;
    q_phase <= 2'h0;
    instr <= x;
    instr_valid <= v;
    {flag_neg, flag_carry, flag_ovf, flag_zero} <= f;
    pc_inc <= pc;
    reg_addr <= wr ? 4'h0 : ra[3:0];
    reg_wdata <= wd;
    reg_we <= wr;
    reg_re <= !wr;
    @(posedge clock);
    q_phase <= 2'h1;
    reg_we <= 1'b0;
    reg_re <= 1'b0;
    #1;
    cmp("reg_rdata", wr ? 32'h0 : er, reg_rdata);
    cmp("branch_busy", k != 0, branch_busy);
    cmp("nop_cycle", 0, nop_cycle);
    @(posedge clock);
    q_phase <= 2'h2;
    @(posedge clock);
    q_phase <= 2'h3;
    #1;
    cmp("pc_load", tk, pc_load);
    cmp("fetch_flush", tk, fetch_flush);
    if (tk != 0) cmp("pc_target", tgt, pc_target);
    cmp("status_we", 0, status_we);
    if (wr) begin
      en = wd[0];
      if (wd[1]) cnt = 0;
    end
    if (k != 0) begin
      lkind = k;
      ltaken = tk;
    end
    if (tk != 0) cnt = (cnt + 1) % 65536;
    prev_br = (k != 0) || (prev_br != 0 && tk == 0 && !v);
    @(posedge clock);
    // empty cycle ignores a fetched taken-looking word
    if (tk != 0) for (j = 0; j < 4; j++) begin
      q_phase <= j[1:0];
      instr <= {8'he6, 8'($urandom)};
      instr_valid <= 1'b1;
      flag_neg <= 1'b1;
      // status read in the empty cycle shows busy, then falls back to zero
      reg_re <= (j == 0);
      reg_addr <= 4'h4;
      #1;
      cmp("nop_cycle", 1, nop_cycle);
      if (j == 1) cmp("reg_rdata", {27'h0, ltaken[0], lkind[2:0], 1'b1}, reg_rdata);
      if (j == 2) cmp("reg_rdata", 0, reg_rdata);
      cmp("pc_load", 0, pc_load);
      cmp("branch_busy", 0, branch_busy);
      @(posedge clock);
    end
  endtask
  // verdict and end of run
  task automatic stop_test();
    $display("checked %0d samples, %0d mismatches", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // watchdog on the whole run
  initial begin
    repeat (20000) @(posedge clock);
    mismatches++;
    stop_test();
  end
  // main sequence
  initial begin
    {rst, instr_valid, flag_neg, flag_carry, flag_ovf, flag_zero, reg_we, reg_re} = 8'h80;
    {q_phase, instr, pc_inc, reg_addr, reg_wdata} = '0;
    {mismatches, samples_checked, cnt, lkind, ltaken} = '0;
    en = 1;
    prev_br = 1;
    void'($urandom(36));
    for (i = 0; i < 8; i++) begin
      q_phase <= i[1:0];
      @(posedge clock);
    end
    rst <= 1'b0;
    // every kind with all flags set and all clear, boundary offsets, pc wrap
    for (i = 0; i < 10; i++) run_cycle({4'he, ops[i / 2], (i % 2) ? 8'h7f : 8'h80},
      1'b1, (i % 2) ? 4'hf : 4'h0, 21'h1ffff0 + 21'(i), 1'b0, 32'h0);
    $display("test kinds done");
    // random mix of branch and other words
    for (i = 0; i < 60; i++) begin
      w = 16'($urandom);
      if ($urandom % 2) w[15:8] = {4'he, ops[$urandom % 5]};
      run_cycle(w, ($urandom % 4) != 0, 4'($urandom), 21'($urandom), 1'b0, 32'h0);
    end
    $display("test random done");
    // disabled unit ignores a taken-looking branch, then enable with counter clear
    run_cycle(16'h0000, 1'b0, 4'h0, '0, 1'b1, 32'h0);
    run_cycle(16'he605, 1'b1, 4'hf, 21'h100, 1'b0, 32'h0);
    run_cycle(16'h0000, 1'b0, 4'h0, '0, 1'b1, 32'h3);
    for (i = 0; i < 20; i++) run_cycle({4'he, ops[$urandom % 5], 8'($urandom)}, 1'b1,
      4'($urandom), 21'($urandom), 1'b0, 32'h0);
    $display("test enable and clear done");
    stop_test();
  end
endmodule
`default_nettype wire

// *** hw/crbu_decode.sv ***
/*
  Opcode matcher: turns an instruction word into a branch kind
  and its raw offset literal. Purely combinational; the caller
  samples it in the decode phase.
*/
`timescale 1ns/10ps
`default_nettype none
`include "crbu_defs.svh"

module crbu_decode
  import crbu_pkg::*;
(
  // instruction word and gate
  input wire logic [15:0] instr,
  input wire logic enable,
  // decoded fields
  output var crbu_kind_t kind,
  output logic [7:0] offset
);

  // match group nibble, then the condition nibble
  always_comb begin
    kind = crbu_none;
    offset = instr[7:0];
    if (enable && (instr[15:12] == `CRBU_OP_GROUP)) begin
      unique case (instr[11:8])
        `CRBU_OP_NEG: kind = crbu_branch_if_negative;
        `CRBU_OP_NC: kind = crbu_branch_if_carry_clear;
        `CRBU_OP_NN: kind = crbu_branch_if_negative_clear;
        `CRBU_OP_NOV: kind = crbu_branch_if_overflow_clear;
        `CRBU_OP_NZ: kind = crbu_branch_if_zero_clear;
        // other group members are not ours
        default: kind = crbu_none;
      endcase
    end
  end

endmodule

`default_nettype wire

// *** hw/crbu_target.sv ***
/*
  Branch target adder: sign-extends the offset literal, doubles
  it and adds it to the already incremented program counter.
  Assumes PCW is above 9.
*/
`timescale 1ns/10ps
`default_nettype none

module crbu_target #(
  parameter int PCW = 21
) (
  // incremented program counter and literal
  input wire logic [PCW-1:0] pc_inc,
  input wire logic [7:0] offset,
  // computed target
  output logic [PCW-1:0] target
);

  // doubled, sign-extended offset
  logic [PCW-1:0] dbl;

  always_comb begin
    dbl = {{(PCW-9){offset[7]}}, offset, 1'b0};
    target = pc_inc + dbl;
  end

endmodule

`default_nettype wire

// *** hw/crbu_top.sv ***
/*
  Conditional relative branch unit: decodes the five one-word
  conditional branches, tests the chosen flag and loads the
  target in phase four, then holds an empty second cycle.
  Assumes q_phase steps Q1..Q4 one per clock, instr and pc_inc
  hold steady through a cycle, and pc_inc is the branch address
  plus two.
*/
// The implementer's own choices: the strobed register port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
`include "crbu_defs.svh"

// Function
// - match upper byte e6 as branch-if-negative
// - branch-if-negative taken when negative set
// - match e3, taken when carry clear
// - match upper byte e7 as negative-clear
// - negative-clear taken when negative flag clear
// - match e5, taken when overflow clear
// - match upper byte e1 as zero-clear
// - zero-clear taken when zero flag clear
// - offset is signed, -128 to 127
// - target is incremented pc plus 2n
// - one word, one cycle, two if taken
// - taken adds an empty cycle, flushes fetch
// - not taken leaves pc at next word
module crbu_top
  import crbu_pkg::*;
#(
  parameter int PCW = 21,
  parameter int CNTW = 16
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // core cycle and instruction
  input wire logic [1:0] q_phase,
  input wire logic [15:0] instr,
  input wire logic instr_valid,
  // status flags
  input wire logic flag_neg,
  input wire logic flag_carry,
  input wire logic flag_ovf,
  input wire logic flag_zero,
  // program counter
  input wire logic [PCW-1:0] pc_inc,
  output logic pc_load,
  output logic [PCW-1:0] pc_target,
  // pipeline control
  output logic fetch_flush,
  output logic nop_cycle,
  output logic branch_busy,
  output logic status_we,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_we,
  input wire logic reg_re,
  output logic [31:0] reg_rdata
);

  // all state of the unit
  typedef struct packed {
    crbu_state_t state;      // run or empty cycle
    crbu_kind_t kind;        // branch in flight
    logic [7:0] offset;      // raw literal
    logic [PCW-1:0] target;  // computed target
    logic pc_load;           // pc write strobe
    logic en;                // unit enable
    crbu_kind_t last_kind;   // last evaluated kind
    logic last_taken;        // its outcome
    logic [CNTW-1:0] cnt;    // taken branches
    logic [31:0] rdata;      // read answer
  } crbu_st_t;

  crbu_st_t st_r;   // registered state
  crbu_st_t st_nxt; // next state

  // decoder and adder wires
  logic dec_en;
  crbu_kind_t dec_kind;
  logic [7:0] dec_off;
  logic [PCW-1:0] tgt;
  logic taken;
  logic cnt_clr;
  logic [CNTW-1:0] cnt_base;

  // words are ignored in the empty cycle and when disabled
  assign dec_en = st_r.en && instr_valid && (st_r.state == crbu_run);

  // opcode matcher
  crbu_decode u_dec (
    .instr(instr),
    .enable(dec_en),
    .kind(dec_kind),
    .offset(dec_off)
  );

  // target adder fed from the latched literal
  crbu_target #(
    .PCW(PCW)
  ) u_tgt (
    .pc_inc(pc_inc),
    .offset(st_r.offset),
    .target(tgt)
  );

  // condition against live flags, sampled in Q3
  // chosen flag test
  assign taken = crbu_cond_met(st_r.kind, flag_neg, flag_carry,
                               flag_ovf, flag_zero);

  // counter clear by a control write
  assign cnt_clr = reg_we && (reg_addr == `CRBU_OFF_CTRL) &&
                   reg_wdata[`CRBU_CTRL_CLR_BIT];

  // next-state logic
  always_comb begin
    st_nxt = st_r;
    st_nxt.pc_load = 1'b0;
    st_nxt.rdata = 32'h0;
    cnt_base = cnt_clr ? {CNTW{1'b0}} : st_r.cnt;
    st_nxt.cnt = cnt_base;
    unique case (q_phase)
      `CRBU_Q1: begin
        st_nxt.kind = dec_kind;
        st_nxt.offset = dec_off;
      end
      `CRBU_Q2: begin
        st_nxt.target = tgt;
      end
      `CRBU_Q3: begin
        if (st_r.kind != crbu_none) begin
          st_nxt.pc_load = taken;
          st_nxt.last_kind = st_r.kind;
          st_nxt.last_taken = taken;
          // a same-cycle clear applies first, then the increment
          if (taken) begin
            st_nxt.cnt = cnt_base + {{(CNTW-1){1'b0}}, 1'b1};
          end
        end
      end
      // phase four: load shows, sequencer steps
      `CRBU_Q4: begin
        st_nxt.kind = crbu_none;
        if (st_r.pc_load) begin
          st_nxt.state = crbu_dead;
        end else begin
          st_nxt.state = crbu_run;
        end
      end
    endcase
    // control write steers the enable
    if (reg_we && (reg_addr == `CRBU_OFF_CTRL)) begin
      st_nxt.en = reg_wdata[`CRBU_CTRL_EN_BIT];
    end
    // read answer for the next cycle only
    if (reg_re) begin
      unique case (reg_addr)
        `CRBU_OFF_CTRL: begin
          st_nxt.rdata[`CRBU_CTRL_EN_BIT] = st_r.en;
        end
        `CRBU_OFF_STAT: begin
          st_nxt.rdata[`CRBU_STAT_BUSY_BIT] = (st_r.state == crbu_dead);
          st_nxt.rdata[`CRBU_STAT_KIND_LSB +: 3] = st_r.last_kind;
          st_nxt.rdata[`CRBU_STAT_TAKEN_BIT] = st_r.last_taken;
        end
        `CRBU_OFF_CNT: begin
          st_nxt.rdata[CNTW-1:0] = st_r.cnt;
        end
        // unmapped offsets read zero
        default: st_nxt.rdata = 32'h0;
      endcase
    end
  end

  // state register
  always_ff @(posedge clock) begin
    if (rst) begin
      st_r <= '0;
      st_r.en <= `CRBU_CTRL_EN_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // outputs from state
  // pc written in phase four only
  assign pc_load = st_r.pc_load;
  assign pc_target = st_r.target;
  assign fetch_flush = st_r.pc_load;
  assign nop_cycle = (st_r.state == crbu_dead);
  assign branch_busy = (st_r.kind != crbu_none);
  assign status_we = 1'b0;
  assign reg_rdata = st_r.rdata;

  // doubled signed offset, for checking
  function automatic logic [PCW-1:0] dbl_off(logic [7:0] o);
    return {{(PCW-9){o[7]}}, o, 1'b0};
  endfunction

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  // decode checks
  a_neg_decode: assert property (
    (q_phase == `CRBU_Q1) && dec_en &&
    (instr[15:8] == {`CRBU_OP_GROUP, `CRBU_OP_NEG})
    |=> st_r.kind == crbu_branch_if_negative)
    else $error("negative branch not decoded");
  a_nc_decode: assert property (
    (q_phase == `CRBU_Q1) && dec_en &&
    (instr[15:8] == {`CRBU_OP_GROUP, `CRBU_OP_NC})
    |=> st_r.kind == crbu_branch_if_carry_clear)
    else $error("carry clear branch not decoded");
  a_nn_decode: assert property (
    (q_phase == `CRBU_Q1) && dec_en &&
    (instr[15:8] == {`CRBU_OP_GROUP, `CRBU_OP_NN})
    |=> st_r.kind == crbu_branch_if_negative_clear)
    else $error("negative clear branch not decoded");
  a_nov_decode: assert property (
    (q_phase == `CRBU_Q1) && dec_en &&
    (instr[15:8] == {`CRBU_OP_GROUP, `CRBU_OP_NOV})
    |=> st_r.kind == crbu_branch_if_overflow_clear)
    else $error("overflow clear branch not decoded");
  a_nz_decode: assert property (
    (q_phase == `CRBU_Q1) && dec_en &&
    (instr[15:8] == {`CRBU_OP_GROUP, `CRBU_OP_NZ})
    |=> st_r.kind == crbu_branch_if_zero_clear)
    else $error("zero clear branch not decoded");

  // condition checks
  a_neg_taken: assert property (
    (q_phase == `CRBU_Q3) && (st_r.kind == crbu_branch_if_negative)
    |=> pc_load == $past(flag_neg))
    else $error("negative branch outcome wrong");
  a_nc_taken: assert property (
    (q_phase == `CRBU_Q3) && (st_r.kind == crbu_branch_if_carry_clear)
    |=> pc_load == !$past(flag_carry))
    else $error("carry clear outcome wrong");
  a_nn_taken: assert property (
    (q_phase == `CRBU_Q3) && (st_r.kind == crbu_branch_if_negative_clear)
    |=> pc_load == !$past(flag_neg))
    else $error("negative clear outcome wrong");
  a_nov_taken: assert property (
    (q_phase == `CRBU_Q3) && (st_r.kind == crbu_branch_if_overflow_clear)
    |=> pc_load == !$past(flag_ovf))
    else $error("overflow clear outcome wrong");
  a_nz_taken: assert property (
    (q_phase == `CRBU_Q3) && (st_r.kind == crbu_branch_if_zero_clear)
    |=> pc_load == !$past(flag_zero))
    else $error("zero clear outcome wrong");

  // target and timing checks
  a_target_value: assert property (
    pc_load |-> pc_target == $past(pc_inc, 2) + dbl_off(st_r.offset))
    else $error("branch target wrong");
  a_taken_len: assert property (
    pc_load |=> nop_cycle [*4] ##1 !nop_cycle)
    else $error("taken branch not two cycles");
  a_dead_drop: assert property (
    nop_cycle && (q_phase == `CRBU_Q1) |=> st_r.kind == crbu_none)
    else $error("word decoded in empty cycle");
  a_not_taken: assert property (
    (q_phase == `CRBU_Q3) && (st_r.kind != crbu_none) && !taken
    |=> !pc_load ##1 !nop_cycle)
    else $error("untaken branch moved pc");
  a_load_phase: assert property (
    pc_load |-> (q_phase == `CRBU_Q4) && $past(q_phase == `CRBU_Q3))
    else $error("pc written outside phase four");
  a_flags_kept: assert property (
    branch_busy || nop_cycle |-> !status_we)
    else $error("status flags written");

  // span checks: a decoded branch holds Q2..Q4, empty cycle idles
  a_busy_span: assert property (
    (q_phase == `CRBU_Q1) && dec_en && (dec_kind != crbu_none)
    |=> branch_busy [*3] ##1 !branch_busy)
    else $error("decoded branch not held three phases");
  a_dead_quiet: assert property (
    nop_cycle |-> !pc_load && !branch_busy)
    else $error("work done in empty cycle");
  a_run_after_dead: assert property (
    nop_cycle && (q_phase == `CRBU_Q4) |=> !nop_cycle)
    else $error("empty cycle longer than one cycle");

  // main scenarios
  c_taken: cover property (pc_load ##1 nop_cycle);
  c_not_taken: cover property (
    (q_phase == `CRBU_Q3) && branch_busy && !taken);
  c_back_to_back: cover property (
    pc_load ##6 branch_busy ##2 pc_load);
  c_disabled: cover property (
    (q_phase == `CRBU_Q1) && !st_r.en && instr_valid && (instr[15:12] == `CRBU_OP_GROUP));
  c_stat_busy: cover property (
    reg_re && (reg_addr == `CRBU_OFF_STAT) && nop_cycle);

endmodule

`default_nettype wire

// *** pkg/crbu_defs.svh ***
/*
  Constants of the conditional relative branch unit: opcode
  patterns, phase codes, register offsets, field positions and
  reset values. Assumes inclusion by bare name, once or more.
*/
`ifndef CRBU_DEFS_SVH
`define CRBU_DEFS_SVH

// upper nibble shared by the whole branch group
`define CRBU_OP_GROUP 4'he
// second nibble of each branch
`define CRBU_OP_NEG 4'h6
`define CRBU_OP_NC 4'h3
`define CRBU_OP_NN 4'h7
`define CRBU_OP_NOV 4'h5
`define CRBU_OP_NZ 4'h1

// instruction cycle phases
`define CRBU_Q1 2'h0
`define CRBU_Q2 2'h1
`define CRBU_Q3 2'h2
`define CRBU_Q4 2'h3

// register byte offsets
`define CRBU_OFF_CTRL 4'h0
`define CRBU_OFF_STAT 4'h4
`define CRBU_OFF_CNT 4'h8

// control fields
`define CRBU_CTRL_EN_BIT 0
`define CRBU_CTRL_CLR_BIT 1
`define CRBU_CTRL_EN_RST 1'h1

// status fields
`define CRBU_STAT_BUSY_BIT 0
`define CRBU_STAT_KIND_LSB 1
`define CRBU_STAT_TAKEN_BIT 4

`endif

// *** pkg/crbu_pkg.sv ***
/*
  Types of the conditional relative branch unit: branch kinds,
  sequencer states and the condition test.
  Assumes nothing of its surroundings.
*/
package crbu_pkg;

  // decoded branch kind, none for any other word
  typedef enum logic [2:0] {
    crbu_none = 3'b000,
    crbu_branch_if_negative = 3'b001,
    crbu_branch_if_carry_clear = 3'b010,
    crbu_branch_if_negative_clear = 3'b011,
    crbu_branch_if_overflow_clear = 3'b100,
    crbu_branch_if_zero_clear = 3'b101
  } crbu_kind_t;

  // sequencer: normal cycle or the empty second cycle
  typedef enum logic [0:0] {
    crbu_run = 1'b0,
    crbu_dead = 1'b1
  } crbu_state_t;

  // condition test of a kind against the status flags
  function automatic logic crbu_cond_met(crbu_kind_t k, logic neg,
                                         logic carry, logic ovf,
                                         logic zero);
    logic met;
    met = 1'b0;
    unique case (k)
      crbu_branch_if_negative: met = neg;
      crbu_branch_if_carry_clear: met = !carry;
      crbu_branch_if_negative_clear: met = !neg;
      crbu_branch_if_overflow_clear: met = !ovf;
      crbu_branch_if_zero_clear: met = !zero;
      default: met = 1'b0;
    endcase
    return met;
  endfunction

endpackage
